// >>> core/sdc_pkg.sv
// shared constants for the synthesizer divider configuration logic
// assumes both ends and the testbench import this package; the link interface uses literal widths
package sdc_pkg;

  // ----------------------------------------------------------------
  // stream and field layout
  // ----------------------------------------------------------------
  localparam int SR_W = 14;
  localparam int M_W = 9;
  localparam int N_W = 2;
  localparam int T_W = 3;
  localparam int T_HI = 13;
  localparam int T_LO = 11;
  localparam int N_HI = 10;
  localparam int N_LO = 9;
  localparam int M_HI = 8;
  localparam int M_LO = 0;
  localparam int SYNC_W = 4 + M_W + N_W;

  // diagnostic select codes
  localparam logic [2:0] DIAG_SHIFT = 3'h0;
  localparam logic [2:0] DIAG_ONE = 3'h1;
  localparam logic [2:0] DIAG_REF16 = 3'h2;
  localparam logic [2:0] DIAG_FB = 3'h3;
  localparam logic [2:0] DIAG_SYNTHESIZED_CLOCK_OUT = 3'h4;
  localparam logic [2:0] DIAG_ZERO = 3'h5;
  localparam logic [2:0] DIAG_BYPASS = 3'h6;
  localparam logic [2:0] DIAG_FOUT4 = 3'h7;

  // reference prescaler and scaled oscillator model
  localparam int REF_DIV_W = 4;
  localparam int VCO_ACC_W = 9;

  // ----------------------------------------------------------------
  // controller timing
  // ----------------------------------------------------------------
  localparam int PCLK_NS = 8;
  localparam int SCLK_HALF_NS = 50;
  localparam int LOAD_PULSE_NS = 50;
  localparam int SETUP_NS = 20;
  localparam int SCLK_HALF_CYC = (SCLK_HALF_NS + PCLK_NS - 1) / PCLK_NS;
  localparam int LOAD_PULSE_CYC = (LOAD_PULSE_NS + PCLK_NS - 1) / PCLK_NS;
  localparam int SETUP_CYC = (SETUP_NS + PCLK_NS - 1) / PCLK_NS;
  localparam int TMR_W = 4;

  // controller register map (byte addresses)
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_PAR = 8'h04;
  localparam logic [7:0] REG_SER = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;
  localparam int CTRL_PAR_GO = 0;
  localparam int CTRL_SER_GO = 1;
  localparam int CTRL_BYP_RUN = 2;
  localparam int ST_BUSY = 0;
  localparam int ST_DIAG = 1;
  localparam int ST_SYNTHESIZED_CLOCK_OUT = 2;
  localparam logic [M_W-1:0] PAR_M_RST = 9'h0c8;
  localparam logic [N_W-1:0] PAR_N_RST = 2'h0;

endpackage

// >>> core/sdc_link_if.sv
// configuration pins between the board controller and the synthesizer
// assumes the testbench instantiates it and joins both ends to it
`timescale 1ns/1ps
interface sdc_link_if;
  logic s_clock;
  logic s_data;
  logic s_load;
  logic p_load;
  logic [8:0] m_par;
  logic [1:0] n_par;
  logic synthesized_clock_out;
  logic diag_out;

  modport dev (
    input s_clock,
    input s_data,
    input s_load,
    input p_load,
    input m_par,
    input n_par,
    output synthesized_clock_out,
    output diag_out
  );

  modport ctl (
    output s_clock,
    output s_data,
    output s_load,
    output p_load,
    output m_par,
    output n_par,
    input synthesized_clock_out,
    input diag_out
  );
endinterface

// >>> core/sdc_sync3.sv
// three-stage input synchroniser with agreement filter, one lane per bit
// assumes inputs are asynchronous to pclk
`timescale 1ns/1ps
module sdc_sync3 #(
  parameter int W = 1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  // ----------------------------------------------------------------
  // per-bit lanes
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < W; gi++) begin : g_lane
      logic s1_q;
      logic s2_q;
      logic s3_q;
      logic out_q;
      // first stage feeds only the second
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          s1_q <= 1'b0;
          s2_q <= 1'b0;
          s3_q <= 1'b0;
        end else begin
          s1_q <= async_in[gi];
          s2_q <= s1_q;
          s3_q <= s2_q;
        end
      end
      // a change counts once stages two and three agree
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          out_q <= 1'b0;
        end else if (s2_q == s3_q) begin
          out_q <= s3_q;
        end
      end
      assign sync_out[gi] = out_q;
    end
  endgenerate

endmodule

// >>> core/sdc_config_dev.sv
// synthesizer end: divider configuration latches, serial shifter,
// scaled divider model and diagnostic output multiplexer
// assumes pclk is the reference clock and link pins are asynchronous
`timescale 1ns/1ps
module sdc_config_dev
  import sdc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  sdc_link_if.dev link,
  output logic [M_W-1:0] cur_m,
  output logic [N_W-1:0] cur_n,
  output logic [T_W-1:0] cur_diag_sel,
  output logic bypass_active
);

  // ----------------------------------------------------------------
  // pin synchronisation and edge detection
  // ----------------------------------------------------------------
  logic [SYNC_W-1:0] pins_raw;
  logic [SYNC_W-1:0] pins_s;
  logic sclk_s;
  logic sdata_s;
  logic sload_s;
  logic pload_s;
  logic [M_W-1:0] mpar_s;
  logic [N_W-1:0] npar_s;
  logic sclk_d1_q;
  logic sload_d1_q;
  logic pload_d1_q;
  logic sclk_rise;
  logic sload_fall;
  logic pload_rise;

  assign pins_raw = {link.s_clock, link.s_data, link.s_load, link.p_load, link.m_par, link.n_par};

  sdc_sync3 #(
    .W(SYNC_W)
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(pins_raw),
    .sync_out(pins_s)
  );

  assign {sclk_s, sdata_s, sload_s, pload_s, mpar_s, npar_s} = pins_s;

  // previous values for edge detection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sclk_d1_q <= 1'b0;
      sload_d1_q <= 1'b0;
      pload_d1_q <= 1'b0;
    end else begin
      sclk_d1_q <= sclk_s;
      sload_d1_q <= sload_s;
      pload_d1_q <= pload_s;
    end
  end

  assign sclk_rise = sclk_s && !sclk_d1_q;
  assign sload_fall = !sload_s && sload_d1_q;
  assign pload_rise = pload_s && !pload_d1_q;

  // ----------------------------------------------------------------
  // serial shift register
  // ----------------------------------------------------------------
  logic [SR_W-1:0] sreg_q;

  // first bit sent ends in the top position, so the stream lands as
  // diag select, post-divider code, feedback value, msb first
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sreg_q <= '0;
    end else if (pload_s && sclk_rise) begin
      sreg_q <= {sreg_q[SR_W-2:0], sdata_s};
    end
  end

  // ----------------------------------------------------------------
  // configuration latches
  // ----------------------------------------------------------------
  logic [M_W-1:0] m_q;
  logic [N_W-1:0] n_q;
  logic [T_W-1:0] diag_q;

  // parallel path wins whenever its strobe is low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      m_q <= PAR_M_RST;
      n_q <= PAR_N_RST;
    end else if (!pload_s || pload_rise) begin
      m_q <= mpar_s;
      n_q <= npar_s;
    end else if (sload_s || sload_fall) begin
      m_q <= sreg_q[M_HI:M_LO];
      n_q <= sreg_q[N_HI:N_LO];
    end
  end

  // diag select moves at the serial strobe fall and is cleared while the parallel strobe is low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      diag_q <= DIAG_SHIFT;
    end else if (!pload_s) begin
      diag_q <= DIAG_SHIFT;
    end else if (sload_fall) begin
      diag_q <= sreg_q[T_HI:T_LO];
    end
  end

  assign cur_m = m_q;
  assign cur_n = n_q;
  assign cur_diag_sel = diag_q;
  assign bypass_active = (diag_q == DIAG_BYPASS);

  // ----------------------------------------------------------------
  // reference prescaler and scaled oscillator model
  // ----------------------------------------------------------------
  logic [REF_DIV_W-1:0] ref_cnt_q;
  logic [VCO_ACC_W-1:0] vco_acc_q;
  logic vco_tick_q;
  logic div_tick;

  // reference divided by 16
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_cnt_q <= '0;
    end else begin
      ref_cnt_q <= ref_cnt_q + 1'b1;
    end
  end

  // carry rate is pclk * M / 512, i.e. (reference/16) * M scaled by 1/32
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vco_acc_q <= '0;
      vco_tick_q <= 1'b0;
    end else begin
      {vco_tick_q, vco_acc_q} <= {1'b0, vco_acc_q} + {1'b0, m_q};
    end
  end

  // in bypass the serial clock replaces the oscillator
  assign div_tick = bypass_active ? sclk_rise : vco_tick_q;

  // ----------------------------------------------------------------
  // feedback counter and post-divider
  // ----------------------------------------------------------------
  logic [M_W-1:0] fb_cnt_q;
  logic fb_out_q;
  logic [7:0] pd_cnt_q;
  logic [7:0] pd_ratio;
  logic synthesized_clock_out_q;
  logic synthesized_clock_out_d1_q;
  logic [1:0] fout4_cnt_q;

  // feedback counter pulses once per M ticks, so its duty is not balanced
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fb_cnt_q <= '0;
      fb_out_q <= 1'b0;
    end else if (div_tick) begin
      if (fb_cnt_q >= m_q - 1'b1) begin
        fb_cnt_q <= '0;
        fb_out_q <= 1'b1;
      end else begin
        fb_cnt_q <= fb_cnt_q + 1'b1;
        fb_out_q <= 1'b0;
      end
    end
  end

  assign pd_ratio = 8'h01 << n_q;

  // output toggles every ratio ticks, keeping a balanced duty
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pd_cnt_q <= '0;
      synthesized_clock_out_q <= 1'b0;
    end else if (div_tick) begin
      if (pd_cnt_q >= pd_ratio - 8'h01) begin
        pd_cnt_q <= '0;
        synthesized_clock_out_q <= !synthesized_clock_out_q;
      end else begin
        pd_cnt_q <= pd_cnt_q + 8'h01;
      end
    end
  end

  // synthesized clock divided by 4
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      synthesized_clock_out_d1_q <= 1'b0;
      fout4_cnt_q <= '0;
    end else begin
      synthesized_clock_out_d1_q <= synthesized_clock_out_q;
      if (synthesized_clock_out_q && !synthesized_clock_out_d1_q) begin
        fout4_cnt_q <= fout4_cnt_q + 2'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // diagnostic output multiplexer
  // ----------------------------------------------------------------
  logic diag_d;
  logic diag_out_q;

  always_comb begin
    unique case (diag_q)
      DIAG_SHIFT: diag_d = sreg_q[SR_W-1];
      DIAG_ONE: diag_d = 1'b1;
      DIAG_REF16: diag_d = ref_cnt_q[REF_DIV_W-1];
      DIAG_FB: diag_d = fb_out_q;
      DIAG_SYNTHESIZED_CLOCK_OUT: diag_d = synthesized_clock_out_q;
      DIAG_ZERO: diag_d = 1'b0;
      DIAG_BYPASS: diag_d = fb_out_q;
      DIAG_FOUT4: diag_d = fout4_cnt_q[1];
    endcase
  end

  // registered pin drivers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      diag_out_q <= 1'b0;
    end else begin
      diag_out_q <= diag_d;
    end
  end

  assign link.diag_out = diag_out_q;
  assign link.synthesized_clock_out = synthesized_clock_out_q;

endmodule

// >>> core/sdc_config_ctl.sv
// board controller end: APB slave registers drive parallel and serial programming
// assumes one pclk domain; device pins returned are asynchronous
`timescale 1ns/1ps
module sdc_config_ctl
  import sdc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  sdc_link_if.ctl link
);

  // ----------------------------------------------------------------
  // registers and bus
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {ST_IDLE, ST_PLOW, ST_BIT_LO, ST_BIT_HI, ST_LSETUP, ST_LHIGH} sdc_state_t;
  sdc_state_t st_q;
  logic [M_W-1:0] pm_q;
  logic [N_W-1:0] pn_q;
  logic [SR_W-1:0] ser_q;
  logic byp_run_q;
  logic [1:0] back_s;
  logic wr;
  logic addr_ok;
  logic busy;

  assign wr = psel && penable && pwrite;
  assign addr_ok = (paddr == REG_CTRL) || (paddr == REG_PAR) || (paddr == REG_SER) || (paddr == REG_STATUS);
  assign busy = (st_q != ST_IDLE);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_ok;

  // read data
  always_comb begin
    prdata = '0;
    unique case (paddr)
      REG_CTRL: prdata[CTRL_BYP_RUN] = byp_run_q;
      REG_PAR: prdata[M_W+N_W-1:0] = {pn_q, pm_q};
      REG_SER: prdata[SR_W-1:0] = ser_q;
      REG_STATUS: prdata[ST_SYNTHESIZED_CLOCK_OUT:ST_BUSY] = {back_s[0], back_s[1], busy};
      default: prdata = '0;
    endcase
  end

  // configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pm_q <= PAR_M_RST;
      pn_q <= PAR_N_RST;
      ser_q <= '0;
      byp_run_q <= 1'b0;
    end else if (wr) begin
      if (paddr == REG_PAR) begin
        pm_q <= pwdata[M_W-1:0];
        pn_q <= pwdata[M_W+N_W-1:M_W];
      end
      if (paddr == REG_SER) begin
        ser_q <= pwdata[SR_W-1:0];
      end
      if (paddr == REG_CTRL) begin
        byp_run_q <= pwdata[CTRL_BYP_RUN];
      end
    end
  end

  sdc_sync3 #(
    .W(2)
  ) u_back (
    .pclk(pclk),
    .presetn(presetn),
    .async_in({link.diag_out, link.synthesized_clock_out}),
    .sync_out(back_s)
  );

  // ----------------------------------------------------------------
  // pin sequencer
  // ----------------------------------------------------------------
  logic [TMR_W-1:0] tmr_q;
  logic [3:0] bit_q;
  logic sclk_q;
  logic sdata_q;
  logic sload_q;
  logic pload_q;

  // parallel strobe held low from reset: parallel values rule at power-up
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= ST_IDLE;
      tmr_q <= '0;
      bit_q <= '0;
      sclk_q <= 1'b0;
      sdata_q <= 1'b0;
      sload_q <= 1'b0;
      pload_q <= 1'b0;
    end else begin
      if (tmr_q != '0) begin
        tmr_q <= tmr_q - 1'b1;
      end
      unique case (st_q)
        ST_IDLE: begin
          if (wr && paddr == REG_CTRL && pwdata[CTRL_PAR_GO]) begin
            pload_q <= 1'b0;
            sclk_q <= 1'b0;
            tmr_q <= TMR_W'(LOAD_PULSE_CYC);
            st_q <= ST_PLOW;
          end else if (wr && paddr == REG_CTRL && pwdata[CTRL_SER_GO] && pload_q) begin
            sclk_q <= 1'b0;
            sdata_q <= ser_q[SR_W-1];
            bit_q <= 4'(SR_W - 1);
            tmr_q <= TMR_W'(SCLK_HALF_CYC);
            st_q <= ST_BIT_LO;
          end else if (byp_run_q && tmr_q == '0) begin
            sclk_q <= !sclk_q;
            tmr_q <= TMR_W'(SCLK_HALF_CYC);
          end
        end
        ST_PLOW: begin
          if (tmr_q == '0) begin
            pload_q <= 1'b1;
            st_q <= ST_IDLE;
          end
        end
        ST_BIT_LO: begin
          if (tmr_q == '0) begin
            sclk_q <= 1'b1;
            tmr_q <= TMR_W'(SCLK_HALF_CYC);
            st_q <= ST_BIT_HI;
          end
        end
        ST_BIT_HI: begin
          if (tmr_q == '0) begin
            sclk_q <= 1'b0;
            tmr_q <= TMR_W'(SCLK_HALF_CYC);
            if (bit_q == '0) begin
              st_q <= ST_LSETUP;
            end else begin
              bit_q <= bit_q - 4'h1;
              sdata_q <= ser_q[bit_q - 4'h1];
              st_q <= ST_BIT_LO;
            end
          end
        end
        ST_LSETUP: begin
          if (tmr_q == '0) begin
            sload_q <= 1'b1;
            tmr_q <= TMR_W'(LOAD_PULSE_CYC);
            st_q <= ST_LHIGH;
          end
        end
        ST_LHIGH: begin
          if (tmr_q == '0) begin
            sload_q <= 1'b0;
            st_q <= ST_IDLE;
          end
        end
      endcase
    end
  end

  assign link.s_clock = sclk_q;
  assign link.s_data = sdata_q;
  assign link.s_load = sload_q;
  assign link.p_load = pload_q;
  assign link.m_par = pm_q;
  assign link.n_par = pn_q;

endmodule

// >>> testbench/sdc_link_checker.sv
// concurrent checks on the configuration pins between the two ends
// assumes it sees the link interface signals and the pclk domain reset
`timescale 1ns/1ps
module sdc_link_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic s_clock,
  input wire logic s_data,
  input wire logic s_load,
  input wire logic p_load,
  input wire logic [8:0] m_par,
  input wire logic [1:0] n_par,
  input wire logic synthesized_clock_out,
  input wire logic diag_out
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // ----------------------------------------------------------------
  // serial strobe and clock shapes
  // ----------------------------------------------------------------
  // high phase of the shift clock, then its fall
  sequence sclk_high_s;
    s_clock [*8] ##1 !s_clock;
  endsequence

  // latch strobe pulse, then its fall
  sequence sload_pulse_s;
    s_load [*8] ##1 !s_load;
  endsequence

  sclk_high_a: assert property ($rose(s_clock) |-> sclk_high_s)
    else $error("shift clock high phase has wrong length");
  sclk_low_a: assert property ($fell(s_clock) |-> !s_clock [*7])
    else $error("shift clock low phase too short");
  sload_pulse_a: assert property ($rose(s_load) |-> sload_pulse_s)
    else $error("serial latch pulse has wrong length");
  sload_quiet_a: assert property (s_load |-> !s_clock && !$past(s_clock, 3))
    else $error("shift clock active near serial latch pulse");
  sdata_setup_a: assert property ($rose(s_clock) |-> s_data == $past(s_data, 3))
    else $error("serial data changed just before shift edge");
  sdata_hold_a: assert property (s_clock |-> $stable(s_data))
    else $error("serial data changed while shift clock high");
  serial_pload_a: assert property (($rose(s_clock) || $rose(s_load)) |-> p_load)
    else $error("serial activity while parallel strobe low");

  // ----------------------------------------------------------------
  // parallel strobe
  // ----------------------------------------------------------------
  pload_pulse_a: assert property ($fell(p_load) |-> !p_load [*8] ##1 p_load)
    else $error("parallel strobe low pulse has wrong length");
  pload_setup_a: assert property ($rose(p_load) |-> m_par == $past(m_par, 3) && n_par == $past(n_par, 3))
    else $error("divider bus not settled at parallel strobe rise");
endmodule

// >>> testbench/tb_synth_divider_config_logic.sv
// testbench joining controller and synthesizer ends over the link
// assumes design files and the link checker are compiled first
`timescale 1ns/1ps
module tb_synth_divider_config_logic
  import sdc_pkg::*;
;
  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [M_W-1:0] cur_m;
  logic [N_W-1:0] cur_n;
  logic [T_W-1:0] cur_diag_sel;
  logic bypass_active;
  logic [31:0] rd;
  logic er;
  int err_total;
  int comparisons;
  int cycles;
  int fr;
  int dr;
  int sr;

  sdc_link_if link ();
  sdc_config_ctl u_sdc_config_ctl (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link(link));
  sdc_config_dev u_sdc_config_dev (.pclk(pclk), .presetn(presetn), .link(link), .cur_m(cur_m),
    .cur_n(cur_n), .cur_diag_sel(cur_diag_sel), .bypass_active(bypass_active));
  sdc_link_checker u_sdc_link_checker (.pclk(pclk), .presetn(presetn), .s_clock(link.s_clock),
    .s_data(link.s_data), .s_load(link.s_load), .p_load(link.p_load), .m_par(link.m_par),
    .n_par(link.n_par), .synthesized_clock_out(link.synthesized_clock_out), .diag_out(link.diag_out));

  // ----------------------------------------------------------------
  // clock, hang limit, reporting
  // ----------------------------------------------------------------
  // 8 ns reference clock
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  // cut a hang short
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 60000) begin
      err_total++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // edge counts may differ by one from phase alone
  task automatic chk_near(input int got, input int exp);
    comparisons++;
    if (got < exp - 1 || got > exp + 1) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // ----------------------------------------------------------------
  // bus and link helpers
  // ----------------------------------------------------------------
  // one apb transfer, waits on pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // poll status until the controller is idle, then let the device settle
  task automatic wait_idle();
    apb(1'b0, REG_STATUS, 32'h0);
    while (rd[ST_BUSY] !== 1'b0) apb(1'b0, REG_STATUS, 32'h0);
    repeat (20) @(posedge pclk);
  endtask

  task automatic ser_load(input logic [2:0] t, input logic [1:0] n, input logic [8:0] m);
    apb(1'b1, REG_SER, {18'h0, t, n, m});
    apb(1'b1, REG_CTRL, 32'h2);
    wait_idle();
  endtask

  // count rising edges of output clock, diagnostic pin and shift clock
  task automatic measure(input int len);
    logic pf;
    logic pd;
    logic ps;
    fr = 0;
    dr = 0;
    sr = 0;
    pf = link.synthesized_clock_out;
    pd = link.diag_out;
    ps = link.s_clock;
    repeat (len) begin
      @(posedge pclk);
      if (link.synthesized_clock_out === 1'b1 && pf === 1'b0) fr++;
      if (link.diag_out === 1'b1 && pd === 1'b0) dr++;
      if (link.s_clock === 1'b1 && ps === 1'b0) sr++;
      pf = link.synthesized_clock_out;
      pd = link.diag_out;
      ps = link.s_clock;
    end
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  // reset state, unmapped access, transparent parallel path, refused serial start
  task automatic t_transparent();
    chk(cur_m, PAR_M_RST);
    chk(cur_diag_sel, 3'h0);
    apb(1'b0, REG_PAR, 32'h0);
    chk(rd, {21'h0, PAR_N_RST, PAR_M_RST});
    apb(1'b0, 8'h10, 32'h0);
    chk(er, 1'b1);
    chk(rd, 32'h0);
    apb(1'b1, REG_PAR, 32'h523);
    repeat (12) @(posedge pclk);
    chk(cur_m, 9'h123);
    chk(cur_n, 2'h2);
    apb(1'b1, REG_SER, 32'h3f55);
    apb(1'b1, REG_CTRL, 32'h2);
    repeat (40) @(posedge pclk);
    chk(cur_diag_sel, 3'h0);
    chk(cur_m, 9'h123);
    $display("transparent path done");
  endtask

  // rising parallel strobe captures, later bus changes do not pass
  task automatic t_par_capture();
    apb(1'b1, REG_CTRL, 32'h1);
    wait_idle();
    apb(1'b1, REG_PAR, 32'h0aa);
    repeat (12) @(posedge pclk);
    chk(cur_m, 9'h123);
    apb(1'b1, REG_CTRL, 32'h1);
    wait_idle();
    chk(cur_m, 9'h0aa);
    chk(cur_n, 2'h0);
    $display("parallel capture done");
  endtask

  // every non-bypass select code, post-divider ratios and output frequency
  task automatic t_serial_codes();
    int dexp[8];
    logic [2:0] t;
    dexp = '{0, 0, 64, 2, 256, 0, 0, 8};
    for (int c = 0; c < 8; c++) begin
      t = 3'(c);
      if (c != 6) begin
        ser_load(t, t[1:0], 9'h100);
        chk(cur_diag_sel, t);
        chk(cur_n, t[1:0]);
        chk(cur_m, 9'h100);
        chk(bypass_active, 1'b0);
        measure(1024);
        chk_near(fr, 256 >> t[1:0]);
        chk_near(dr, dexp[c]);
        if (c == 0 || c == 1 || c == 5) begin
          chk(link.diag_out, (c == 1));
          apb(1'b0, REG_STATUS, 32'h0);
          chk(rd[ST_DIAG], (c == 1));
        end
      end
    end
    $display("serial codes done");
  endtask

  // parallel load after serial overrides dividers and clears the select
  task automatic t_priority();
    apb(1'b1, REG_PAR, 32'h350);
    apb(1'b1, REG_CTRL, 32'h1);
    wait_idle();
    chk(cur_m, 9'h150);
    chk(cur_n, 2'h1);
    chk(cur_diag_sel, 3'h0);
    $display("priority done");
  endtask

  // serial clock drives both dividers in bypass
  task automatic t_bypass();
    ser_load(3'h6, 2'h0, 9'h004);
    chk(bypass_active, 1'b1);
    apb(1'b1, REG_CTRL, 32'h4);
    measure(1400);
    // each half period of the bypass clock spans the timer load plus its zero cycle
    chk_near(sr, 1400 / (2 * (SCLK_HALF_CYC + 1)));
    chk_near(fr, sr / 2);
    chk_near(dr, sr / 4);
    $display("bypass done");
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    err_total = 0;
    comparisons = 0;
    cycles = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    repeat (8) @(posedge pclk);
    t_transparent();
    t_par_capture();
    t_serial_codes();
    t_priority();
    t_bypass();
    report_and_stop();
  end
endmodule
